// File: logic/bcs_buck_control.sv
`timescale 1ns/100ps
`default_nettype none
module bcs_buck_control #(
    parameter int ARM_CYCLES = bcs_pkg::ARM_CYCLES,
    parameter int RESUME_CYCLES = bcs_pkg::RESUME_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic por_released_in,
    input wire logic osc_supply_ok_in,
    input wire logic conv_supply_ok_in,
    input wire logic coil_over_limit_in,
    input wire logic [bcs_pkg::VIN_W-1:0] vin_decivolt_in,
    input wire logic [bcs_pkg::PER_W-1:0] on_time_req_in,
    input wire logic converter_disable_in,
    input wire logic converter_bypass_in,
    input wire logic aux_regulator_powerdown_in,
    input wire logic [2:0] switch_frequency_select_in,
    output logic hs_on_out,
    output logic ls_on_out,
    output logic startup_source_en_out,
    output logic switch_ctrl_power_out,
    output logic aux_regulator_en_out,
    output logic aux_discharge_en_out,
    output logic [2:0] conv_state_out
);
    // ****************************************
    // parameter checks
    // ****************************************
    if (ARM_CYCLES < 1 || ARM_CYCLES >= (1 << bcs_pkg::TIMER_W))
        $error("ARM_CYCLES out of range");
    if (RESUME_CYCLES < 1 || RESUME_CYCLES >= (1 << bcs_pkg::TIMER_W))
        $error("RESUME_CYCLES out of range");

    localparam logic [bcs_pkg::TIMER_W-1:0] ARM_LAST = bcs_pkg::TIMER_W'(ARM_CYCLES - 1);
    localparam logic [bcs_pkg::TIMER_W-1:0] RESUME_LAST = bcs_pkg::TIMER_W'(RESUME_CYCLES - 1);
    localparam logic [bcs_pkg::PER_W-1:0] MIN_OFF = bcs_pkg::PER_W'(bcs_pkg::MIN_OFF_CYCLES);
    localparam logic [7:0] DUTY_CAP = 8'(bcs_pkg::DUTY_CAP_DECIVOLT);

    typedef struct packed {
        bcs_pkg::bcs_state_t state;
        logic [bcs_pkg::TIMER_W-1:0] timer;
        logic [bcs_pkg::PER_W-1:0] period;
        logic [bcs_pkg::PER_W-1:0] on_max;
        logic startup_src;
        logic ctrl_pwr;
        logic aux_en;
        logic aux_dis;
    } bcs_ctrl_t;

    bcs_ctrl_t r;
    bcs_ctrl_t n;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0] pins_s;
    logic por_ok;
    logic sup_ok;
    logic [bcs_pkg::PER_W-1:0] per_sel;
    logic [17:0] cap_prod;
    logic [17:0] cap_quot;
    logic [bcs_pkg::PER_W-1:0] cap_on;

    bcs_sync #(
        .W(4)
    ) u_sync (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .d_in({coil_over_limit_in, conv_supply_ok_in, osc_supply_ok_in, por_released_in}),
        .q_out(pins_s)
    );

    assign por_ok = pins_s[0];
    assign sup_ok = pins_s[0] & pins_s[1] & pins_s[2];

    // ****************************************
    // period and duty ceiling
    // ****************************************
    always_comb
    begin
        per_sel = bcs_pkg::period_of(switch_frequency_select_in);
        cap_prod = 18'(per_sel * DUTY_CAP);
        if (vin_decivolt_in == '0)
            cap_quot = 18'(per_sel);
        else
            cap_quot = cap_prod / 18'(vin_decivolt_in);
        cap_on = (cap_quot > 18'(per_sel)) ? per_sel : cap_quot[bcs_pkg::PER_W-1:0];
    end

    // ****************************************
    // converter state machine
    // ****************************************
    always_comb
    begin
        n = r;
        n.period = per_sel;
        n.on_max = bcs_pkg::min_len(cap_on, per_sel - MIN_OFF);
        case (r.state)
            bcs_pkg::ST_STARTUP:
            begin
                if (sup_ok)
                begin
                    n.state = bcs_pkg::ST_ARM;
                    n.timer = ARM_LAST;
                end
            end
            bcs_pkg::ST_ARM:
            begin
                if (!sup_ok)
                    n.state = bcs_pkg::ST_STARTUP;
                else if (r.timer != '0)
                    n.timer = r.timer - 18'h00001;
                else if (converter_disable_in)
                    n.state = bcs_pkg::ST_SLEEP;
                else if (converter_bypass_in)
                begin
                    n.state = bcs_pkg::ST_BYPASS;
                    n.timer = RESUME_LAST;
                end
                else
                begin
                    n.state = bcs_pkg::ST_RUN;
                    n.timer = ARM_LAST;
                end
            end
            bcs_pkg::ST_RUN:
            begin
                if (!sup_ok || converter_disable_in)
                begin
                    n.state = bcs_pkg::ST_ARM;
                    n.timer = ARM_LAST;
                end
                else if (!converter_bypass_in)
                    n.timer = ARM_LAST;
                else if (r.timer != '0)
                    n.timer = r.timer - 18'h00001;
                else
                begin
                    n.state = bcs_pkg::ST_BYPASS;
                    n.timer = RESUME_LAST;
                end
            end
            bcs_pkg::ST_BYPASS:
            begin
                if (!sup_ok)
                    n.state = bcs_pkg::ST_STARTUP;
                else if (converter_disable_in)
                begin
                    n.state = bcs_pkg::ST_ARM;
                    n.timer = ARM_LAST;
                end
                else if (converter_bypass_in)
                    n.timer = RESUME_LAST;
                else if (r.timer != '0)
                    n.timer = r.timer - 18'h00001;
                else
                begin
                    n.state = bcs_pkg::ST_RUN;
                    n.timer = ARM_LAST;
                end
            end
            bcs_pkg::ST_SLEEP:
            begin
                if (!por_ok)
                    n.state = bcs_pkg::ST_STARTUP;
                else if (!converter_disable_in)
                begin
                    n.state = bcs_pkg::ST_ARM;
                    n.timer = ARM_LAST;
                end
            end
            default:
                n.state = bcs_pkg::ST_STARTUP;
        endcase
        n.startup_src = (n.state == bcs_pkg::ST_STARTUP) || (n.state == bcs_pkg::ST_BYPASS);
        n.ctrl_pwr = (n.state == bcs_pkg::ST_ARM) || (n.state == bcs_pkg::ST_RUN);
        n.aux_en = !aux_regulator_powerdown_in;
        n.aux_dis = aux_regulator_powerdown_in;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            r <= '0;
        else
            r <= n;
    end

    // ****************************************
    // switching cycle generator
    // ****************************************
    bcs_pwm_if pif ();

    assign pif.run = (r.state == bcs_pkg::ST_RUN);
    assign pif.period = r.period;
    assign pif.on_max = r.on_max;
    assign pif.on_req = on_time_req_in;
    assign pif.over_limit = pins_s[3];

    bcs_pwm u_pwm (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .pif(pif)
    );

    assign hs_on_out = pif.hs;
    assign ls_on_out = pif.ls;
    assign startup_source_en_out = r.startup_src;
    assign switch_ctrl_power_out = r.ctrl_pwr;
    assign aux_regulator_en_out = r.aux_en;
    assign aux_discharge_en_out = r.aux_dis;
    assign conv_state_out = r.state;

    // ****************************************
    // checks
    // ****************************************
    logic [bcs_pkg::TIMER_W-1:0] dwell;
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || (n.state != r.state))
            dwell <= 18'h00001;
        else if (dwell != '1)
            dwell <= dwell + 18'h00001;
    end

    property p_no_switch_bad_supply;
        @(posedge clk_sys_in) disable iff (rst_in)
        !sup_ok [*3] |-> !hs_on_out && !ls_on_out;
    endproperty
    a_no_switch_bad_supply: assert property (p_no_switch_bad_supply) else $error("switching without supply");

    property p_reset_startup;
        @(posedge clk_sys_in)
        $fell(rst_in) |-> (r.state == bcs_pkg::ST_STARTUP) ##1
            ((r.state == bcs_pkg::ST_STARTUP) && startup_source_en_out);
    endproperty
    a_reset_startup: assert property (p_reset_startup) else $error("not in startup after reset");

    property p_arm_dwell;
        @(posedge clk_sys_in) disable iff (rst_in)
        (r.state == bcs_pkg::ST_RUN) && ($past(r.state) == bcs_pkg::ST_ARM) |-> $past(dwell) == ARM_CYCLES;
    endproperty
    a_arm_dwell: assert property (p_arm_dwell) else $error("arm dwell wrong before run");

    property p_arm_off;
        @(posedge clk_sys_in) disable iff (rst_in)
        (r.state == bcs_pkg::ST_ARM) |-> switch_ctrl_power_out ##1 (!hs_on_out && !ls_on_out);
    endproperty
    a_arm_off: assert property (p_arm_off) else $error("switch driven in arm");

    property p_supply_loss;
        @(posedge clk_sys_in) disable iff (rst_in)
        (r.state == bcs_pkg::ST_RUN) && !sup_ok ##1 !sup_ok |-> (r.state == bcs_pkg::ST_ARM) ##1 (r.state == bcs_pkg::ST_STARTUP);
    endproperty
    a_supply_loss: assert property (p_supply_loss) else $error("supply loss did not pass arm to startup");

    property p_disable_leave;
        @(posedge clk_sys_in) disable iff (rst_in)
        (r.state == bcs_pkg::ST_RUN) && sup_ok && converter_disable_in |=> r.state == bcs_pkg::ST_ARM;
    endproperty
    a_disable_leave: assert property (p_disable_leave) else $error("disable did not enter arm");

    property p_sleep_entry;
        @(posedge clk_sys_in) disable iff (rst_in)
        (r.state == bcs_pkg::ST_SLEEP) && ($past(r.state) != bcs_pkg::ST_SLEEP) |->
            ($past(r.state) == bcs_pkg::ST_ARM) && ($past(dwell) == ARM_CYCLES) && !switch_ctrl_power_out;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry timing wrong");

    property p_sleep_exit;
        @(posedge clk_sys_in) disable iff (rst_in)
        (r.state == bcs_pkg::ST_SLEEP) && !por_ok |=> r.state == bcs_pkg::ST_STARTUP;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit) else $error("sleep not left on power-on reset");

    property p_bypass_quiet;
        @(posedge clk_sys_in) disable iff (rst_in)
        (r.state == bcs_pkg::ST_BYPASS) [*2] |-> startup_source_en_out && !hs_on_out && !ls_on_out;
    endproperty
    a_bypass_quiet: assert property (p_bypass_quiet) else $error("switching in bypass");

    property p_bypass_resume;
        @(posedge clk_sys_in) disable iff (rst_in)
        (r.state == bcs_pkg::ST_RUN) && ($past(r.state) == bcs_pkg::ST_BYPASS) |->
            !$past(converter_bypass_in) && ($past(r.timer) == '0);
    endproperty
    a_bypass_resume: assert property (p_bypass_resume) else $error("bypass left early");

    property p_aux_pd;
        @(posedge clk_sys_in) disable iff (rst_in)
        aux_regulator_powerdown_in |=> aux_discharge_en_out && !aux_regulator_en_out;
    endproperty
    a_aux_pd: assert property (p_aux_pd) else $error("aux regulator not powered down");

    property p_period_sel;
        @(posedge clk_sys_in) disable iff (rst_in)
        $stable(switch_frequency_select_in) |=> r.period == bcs_pkg::period_of($past(switch_frequency_select_in));
    endproperty
    a_period_sel: assert property (p_period_sel) else $error("period does not follow select");
endmodule
`default_nettype wire

// File: logic/bcs_pkg.sv
`default_nettype none
package bcs_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_MHZ = 250;
    localparam int ARM_TIME_US = 1000;
    localparam int BYPASS_RESUME_US = 40;
    localparam int MIN_OFF_NS = 150;
    localparam int OC_RECHECK_NS = 200;
    localparam int ARM_CYCLES = ARM_TIME_US * CLK_MHZ;
    localparam int RESUME_CYCLES = BYPASS_RESUME_US * CLK_MHZ;
    localparam int MIN_OFF_CYCLES = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;
    localparam int RECHECK_CYCLES = (OC_RECHECK_NS * CLK_MHZ) / 1000;

    // ****************************************
    // widths and limits
    // ****************************************
    localparam int TIMER_W = 18;
    localparam int PER_W = 10;
    localparam int VIN_W = 9;
    localparam int DUTY_CAP_DECIVOLT = 192;
    localparam logic [2:0] FSEL_RESET = 3'h0;

    // ****************************************
    // frequency select table in kHz
    // ****************************************
    localparam int FREQ_KHZ_0 = 1000;
    localparam int FREQ_KHZ_1 = 1250;
    localparam int FREQ_KHZ_2 = 1670;
    localparam int FREQ_KHZ_3 = 2000;
    localparam int FREQ_KHZ_4 = 500;
    localparam int FREQ_KHZ_5 = 625;
    localparam int FREQ_KHZ_6 = 710;
    localparam int FREQ_KHZ_7 = 830;

    // ****************************************
    // converter states
    // ****************************************
    typedef enum logic [2:0] {
        ST_STARTUP = 3'h0,
        ST_ARM = 3'h1,
        ST_RUN = 3'h2,
        ST_SLEEP = 3'h3,
        ST_BYPASS = 3'h4
    } bcs_state_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_CYCLE = 2'h1,
        PH_WAIT = 2'h2
    } bcs_phase_t;

    function automatic logic [PER_W-1:0] period_of(input logic [2:0] sel);
        int khz;
        case (sel)
            3'h0: khz = FREQ_KHZ_0;
            3'h1: khz = FREQ_KHZ_1;
            3'h2: khz = FREQ_KHZ_2;
            3'h3: khz = FREQ_KHZ_3;
            3'h4: khz = FREQ_KHZ_4;
            3'h5: khz = FREQ_KHZ_5;
            3'h6: khz = FREQ_KHZ_6;
            default: khz = FREQ_KHZ_7;
        endcase
        return PER_W'((CLK_MHZ * 1000) / khz);
    endfunction

    function automatic logic [PER_W-1:0] min_len(input logic [PER_W-1:0] a, input logic [PER_W-1:0] b);
        return (a < b) ? a : b;
    endfunction

endpackage
`default_nettype wire

// File: logic/bcs_pwm_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bcs_pwm_if;
    logic run;
    logic [bcs_pkg::PER_W-1:0] period;
    logic [bcs_pkg::PER_W-1:0] on_max;
    logic [bcs_pkg::PER_W-1:0] on_req;
    logic over_limit;
    logic hs;
    logic ls;
    modport ctrl (output run, period, on_max, on_req, over_limit, input hs, ls);
    modport gen (input run, period, on_max, on_req, over_limit, output hs, ls);
endinterface
`default_nettype wire

// File: logic/bcs_sync.sv
`timescale 1ns/100ps
`default_nettype none
module bcs_sync #(
    parameter int W = 4
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } bcs_sync_t;

    bcs_sync_t r;
    bcs_sync_t n;

    // ****************************************
    // three stages, change taken when stages two and three agree
    // ****************************************
    always_comb
    begin
        n = r;
        n.s1 = d_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.q = (~(r.s2 ^ r.s3) & r.s3) | ((r.s2 ^ r.s3) & r.q);
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            r <= '0;
        else
            r <= n;
    end

    assign q_out = r.q;
endmodule
`default_nettype wire

// File: logic/bcs_pwm.sv
`timescale 1ns/100ps
`default_nettype none
module bcs_pwm (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    bcs_pwm_if.gen pif
);
    typedef struct packed {
        bcs_pkg::bcs_phase_t phase;
        logic [bcs_pkg::PER_W-1:0] pos;
        logic [bcs_pkg::PER_W-1:0] on_len;
        logic hs;
        logic ls;
    } bcs_pwm_t;

    localparam logic [bcs_pkg::PER_W-1:0] RECHECK_LAST = bcs_pkg::PER_W'(bcs_pkg::RECHECK_CYCLES - 1);

    bcs_pwm_t r;
    bcs_pwm_t n;
    bcs_pwm_t st;

    // ****************************************
    // switching cycle generator
    // ****************************************
    always_comb
    begin
        st = r;
        st.pos = '0;
        if (pif.over_limit)
            st.phase = bcs_pkg::PH_WAIT;
        else
        begin
            st.phase = bcs_pkg::PH_CYCLE;
            st.on_len = bcs_pkg::min_len(pif.on_req, pif.on_max);
        end
        n = r;
        case (r.phase)
            bcs_pkg::PH_IDLE:
            begin
                if (pif.run)
                    n = st;
            end
            bcs_pkg::PH_CYCLE:
            begin
                if (!pif.run)
                    n.phase = bcs_pkg::PH_IDLE;
                else if (r.pos >= pif.period - 10'h001)
                    n = st;
                else
                    n.pos = r.pos + 10'h001;
            end
            bcs_pkg::PH_WAIT:
            begin
                if (!pif.run)
                    n.phase = bcs_pkg::PH_IDLE;
                else if (r.pos >= RECHECK_LAST)
                    n = st;
                else
                    n.pos = r.pos + 10'h001;
            end
            default:
                n.phase = bcs_pkg::PH_IDLE;
        endcase
        n.hs = (n.phase == bcs_pkg::PH_CYCLE) && (n.pos < n.on_len);
        n.ls = (n.phase == bcs_pkg::PH_CYCLE) && !n.hs;
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            r <= '0;
        else
            r <= n;
    end

    assign pif.hs = r.hs;
    assign pif.ls = r.ls;

    // ****************************************
    // checks
    // ****************************************
    logic [bcs_pkg::PER_W-1:0] hs_len;
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || !r.hs)
            hs_len <= '0;
        else
            hs_len <= hs_len + 10'h001;
    end

    property p_hs_within_cap;
        @(posedge clk_sys_in) disable iff (rst_in)
        r.hs |-> (hs_len < r.on_len) && ((r.pos != '0) || (r.on_len <= $past(pif.on_max)));
    endproperty
    a_hs_within_cap: assert property (p_hs_within_cap) else $error("high side on longer than allowed");

    property p_skip_when_over;
        @(posedge clk_sys_in) disable iff (rst_in)
        (r.phase == bcs_pkg::PH_WAIT) && pif.run && pif.over_limit |=> !r.hs [*1];
    endproperty
    a_skip_when_over: assert property (p_skip_when_over) else $error("switched during overcurrent skip");

    property p_never_both;
        @(posedge clk_sys_in) disable iff (rst_in)
        !(r.hs && r.ls);
    endproperty
    a_never_both: assert property (p_never_both) else $error("both switches on");
endmodule
`default_nettype wire

// File: verification/bcs_mcu_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// controller writing the converter control bits
// ****************************************
module bcs_mcu_model (
    input wire logic clk_sys_in,
    output logic converter_disable_out,
    output logic converter_bypass_out,
    output logic aux_regulator_powerdown_out,
    output logic [2:0] switch_frequency_select_out
);
    initial
    begin
        converter_disable_out = 1'b0;
        converter_bypass_out = 1'b0;
        aux_regulator_powerdown_out = 1'b0;
        switch_frequency_select_out = 3'h0;
    end

    // bits change just after an edge and stay as levels
    task automatic write_bits(input logic d, input logic b, input logic p, input logic [2:0] f);
        @(posedge clk_sys_in);
        #1;
        converter_disable_out = d;
        converter_bypass_out = b;
        aux_regulator_powerdown_out = p;
        switch_frequency_select_out = f;
    endtask
endmodule
`default_nettype wire

// File: verification/buck_converter_state_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// converter sequencing bench
// ****************************************
module buck_converter_state_control_bench;
    localparam int ARM = 20;
    localparam int RES = 8;
    localparam int PER [8] = '{250, 200, 149, 125, 500, 400, 352, 301};
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic por = 1'b0, osc = 1'b0, conv = 1'b0, coil = 1'b0;
    logic [8:0] vin = 9'h000;
    logic [9:0] on_req = 10'h032;
    logic dis, converter_bypass, pd, hs, ls, src, cpw, aen, adis;
    logic [2:0] fsel, st;
    int n_mismatch = 0, checks = 0, cyc = 0;

    always #2 clk_sys_in = ~clk_sys_in;

    bcs_mcu_model MCU (.clk_sys_in(clk_sys_in), .converter_disable_out(dis), .converter_bypass_out(converter_bypass),
        .aux_regulator_powerdown_out(pd), .switch_frequency_select_out(fsel));

    bcs_buck_control #(.ARM_CYCLES(ARM), .RESUME_CYCLES(RES)) DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .por_released_in(por), .osc_supply_ok_in(osc), .conv_supply_ok_in(conv), .coil_over_limit_in(coil),
        .vin_decivolt_in(vin), .on_time_req_in(on_req), .converter_disable_in(dis), .converter_bypass_in(converter_bypass),
        .aux_regulator_powerdown_in(pd), .switch_frequency_select_in(fsel), .hs_on_out(hs), .ls_on_out(ls),
        .startup_source_en_out(src), .switch_ctrl_power_out(cpw), .aux_regulator_en_out(aen),
        .aux_discharge_en_out(adis), .conv_state_out(st));

    task automatic step();
        @(posedge clk_sys_in);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] lo, input logic [15:0] hi, input logic [15:0] got);
        checks++;
        if (!(got >= lo && got <= hi) || $isunknown(got))
        begin
            n_mismatch++;
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic wait_st(input logic [2:0] s, input int lim, output logic [15:0] n);
        n = 16'h0000;
        while (st !== s && n < lim)
        begin
            step();
            n++;
        end
    endtask

    task automatic pwm(output logic [15:0] on, output logic [15:0] off, output logic bad);
        int k;
        on = 16'h0000;
        off = 16'h0000;
        bad = 1'b0;
        for (k = 0; k < 2000 && hs === 1'b1; k++) step();
        for (k = 0; k < 2000 && hs !== 1'b1; k++) step();
        while (hs === 1'b1 && on < 2000)
        begin
            bad |= (ls !== 1'b0);
            step();
            on++;
        end
        while (hs !== 1'b1 && off < 2000)
        begin
            bad |= (ls !== 1'b1);
            step();
            off++;
        end
    endtask

    task automatic t_startup();
        step();
        chk("state", 16'h0000, 16'h0000, st);
        por = 1'b1;
        osc = 1'b1;
        repeat (10) step();
        chk("src", 16'h0001, 16'h0001, src);
        chk("state held", 16'h0000, 16'h0000, st);
    endtask

    task automatic t_arm();
        logic [15:0] n;
        logic bad;
        bad = 1'b0;
        conv = 1'b1;
        wait_st(3'h1, 10, n);
        n = 16'h0000;
        while (st === 3'h1 && n < 100)
        begin
            bad |= (cpw !== 1'b1);
            step();
            bad |= (hs !== 1'b0) || (ls !== 1'b0);
            n++;
        end
        chk("arm dwell", ARM, ARM, n);
        chk("arm switches off", 16'h0000, 16'h0000, bad);
        chk("run", 16'h0002, 16'h0002, st);
    endtask

    task automatic t_pwm();
        logic [15:0] on, off;
        logic bad;
        for (int c = 0; c < 8; c++)
        begin
            MCU.write_bits(1'b0, 1'b0, 1'b0, 3'(c));
            pwm(on, off, bad);
            pwm(on, off, bad);
            chk("period", PER[c], PER[c], on + off);
            chk("on time", 16'h0032, 16'h0032, on);
            chk("anti phase", 16'h0000, 16'h0000, bad);
        end
        MCU.write_bits(1'b0, 1'b0, 1'b0, 3'h0);
        on_req = 10'h3E8;
        pwm(on, off, bad);
        pwm(on, off, bad);
        chk("min off", 16'h00D4, 16'h00D4, on);
        vin = 9'h0F0;
        pwm(on, off, bad);
        pwm(on, off, bad);
        chk("duty cap", 16'h00C8, 16'h00C8, on);
        vin = 9'h000;
        on_req = 10'h032;
    endtask

    task automatic t_oc();
        logic [15:0] n;
        coil = 1'b1;
        repeat (10) step();
        for (n = 16'h0000; n < 300 && hs === 1'b1; n++) step();
        n = 16'h0000;
        repeat (300)
        begin
            step();
            n += 16'(hs === 1'b1);
        end
        chk("skip over limit", 16'h0000, 16'h0000, n);
        coil = 1'b0;
        for (n = 16'h0000; n < 200 && hs !== 1'b1; n++) step();
        chk("recheck", 16'h0001, 16'h003C, n);
    endtask

    task automatic t_bypass();
        logic [15:0] n;
        MCU.write_bits(1'b0, 1'b1, 1'b0, 3'h0);
        wait_st(3'h4, 60, n);
        chk("bypass entry", ARM, ARM + 2, n);
        step();
        chk("bypass src", 16'h0004, 16'h0004, {src, hs, cpw});
        MCU.write_bits(1'b0, 1'b0, 1'b0, 3'h0);
        wait_st(3'h2, 60, n);
        chk("resume", RES, RES + 2, n);
    endtask

    task automatic t_sleep();
        logic [15:0] n;
        MCU.write_bits(1'b1, 1'b0, 1'b0, 3'h0);
        step();
        chk("via arm", 16'h0001, 16'h0001, st);
        wait_st(3'h3, 60, n);
        chk("sleep entry", ARM - 1, ARM + 1, n);
        step();
        chk("sleep power", 16'h0000, 16'h0000, {src, cpw, hs, ls});
        MCU.write_bits(1'b0, 1'b0, 1'b0, 3'h0);
        step();
        chk("sleep exit", 16'h0001, 16'h0001, st);
        wait_st(3'h2, 40, n);
        MCU.write_bits(1'b1, 1'b1, 1'b0, 3'h0);
        wait_st(3'h3, 60, n);
        chk("disable wins", 16'h0003, 16'h0003, st);
        por = 1'b0;
        wait_st(3'h0, 10, n);
        chk("por exit", 16'h0000, 16'h0000, st);
        MCU.write_bits(1'b0, 1'b0, 1'b0, 3'h0);
        por = 1'b1;
        wait_st(3'h2, 60, n);
        conv = 1'b0;
        wait_st(3'h1, 10, n);
        chk("loss via arm", 16'h0001, 16'h0001, st);
        wait_st(3'h0, 10, n);
        chk("loss startup", 16'h0000, 16'h0000, {st, hs});
    endtask

    task automatic t_aux();
        MCU.write_bits(1'b0, 1'b0, 1'b1, 3'h0);
        repeat (2) step();
        chk("aux off", 16'h0001, 16'h0001, {aen, adis});
        MCU.write_bits(1'b0, 1'b0, 1'b0, 3'h0);
        repeat (2) step();
        chk("aux on", 16'h0002, 16'h0002, {aen, adis});
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_mismatch++;
            results();
        end
    end

    initial
    begin
        repeat (12) step();
        rst_in = 1'b0;
        t_startup();
        t_arm();
        t_pwm();
        t_oc();
        t_bypass();
        t_sleep();
        t_aux();
        results();
    end
endmodule
`default_nettype wire
